// file: verilog/rmp_defines.svh
`ifndef RMP_DEFINES_SVH
`define RMP_DEFINES_SVH

// register counts
`define RMP_NUM_IN_REGS 9
`define RMP_NUM_OUT_REGS 8
`define RMP_NUM_MAP_REGS 17

// byte offsets: map register k sits at k*4, then oscillator control
`define RMP_MAP_BASE 8'h00
`define RMP_OSC_CTRL_OFFSET 8'h44
`define RMP_IRQ1_SEL_INDEX 0

// field layout of the external interrupt 1 select register
`define RMP_IRQ1_SEL_MSB 12
`define RMP_IRQ1_SEL_LSB 8
`define RMP_PIN_SEL_TIED_LOW 5'h1f
`define RMP_PIN_SEL_MAX 5'h19

// implemented-bit masks and reset values
`define RMP_IRQ1_MASK 16'h1f00
`define RMP_IN_MASK 16'h1f1f
`define RMP_OUT_MASK 16'h1f1f
`define RMP_IRQ1_RESET 16'h1f00
`define RMP_IN_RESET 16'h1f1f
`define RMP_OUT_RESET 16'h0000

// oscillator control: lock bit and unlock keys
`define RMP_LOCK_BIT 6
`define RMP_LOCK_RESET 1'h0
`define RMP_KEY_FIRST 8'h46
`define RMP_KEY_SECOND 8'h57

`endif

// file: verilog/rmp_pkg.sv
package rmp_pkg;

    // unlock sequence progress
    typedef enum logic [1:0] {
        RMP_KEY_IDLE = 2'b00,
        RMP_KEY_GOT_FIRST = 2'b01,
        RMP_KEY_ARMED = 2'b10
    } rmp_key_state_e;

endpackage

// file: verilog/rmp_pin_remap.sv
`timescale 1ns/100ps
`default_nettype none
`include "rmp_defines.svh"

module rmp_pin_remap
    import rmp_pkg::*;
#(
    parameter int NUM_PINS = 26
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // pins and peripheral side
    input wire logic [NUM_PINS-1:0] i_remappable_pin,
    output logic o_ext_irq1_input,
    output logic o_pin_map_write_lock
);

    // register map, one aligned word per register:
    //   word 0      interrupt 1 select, field in bits 12:8
    //   words 1-8   the other input selects, fields 12:8 and 4:0
    //   words 9-16  output selects, fields 12:8 and 4:0
    //   byte 0x44   oscillator control, only the lock in bit 6
    // any other address answers with the error flag; a write there only restarts the key sequence
    //
    // bus timing:
    //   the setup cycle samples the address and builds the answer
    //   ready rises in the first access cycle, so there are no waits
    //   a write lands on the edge that sees select, enable and ready
    //   the error flag stands for that one cycle only; read data holds until the next setup
    //   back-to-back transfers are fine, setup may follow access
    //
    // write lock:
    //   the lock starts cleared, so boot code may map pins at once
    //   a locked write still completes cleanly and changes nothing
    //   the lock moves only on the write that follows the two keys
    //   the keys go to the low byte of the oscillator control word
    //   any write elsewhere between the keys starts the sequence over
    //   a repeated first key keeps the sequence in its first step
    //   reads never disturb the sequence
    //   writes to the control word outside the armed step leave the lock unchanged
    //
    // interrupt 1 path:
    //   the pins come from the pads and may change at any time
    //   two flops bring them into the clock domain first
    //   the selected pin then passes one more flop to the output
    //   so a pin edge shows at the output three edges later
    //   a new select shows one edge after its register updates
    //   codes past the last pin, and all ones, give a steady low
    //   a pulse shorter than one clock may be missed; that is the
    //   price of a clean synchroniser and is fine for level inputs
    //
    // other selects:
    //   they only store their fields; the peripherals that would use
    //   them sit outside this block
    //   their reset value leaves every input tied low and every pin
    //   on its default port function
    //
    // parameters:
    //   the pin count sets the width of the pin input bus
    //   select codes at or past the pin count read as a steady low
    //   the select field stays five bits whatever the pin count
    //
    // reset:
    //   synchronous and active low, held for at least one edge
    //   every bus answer flop clears, so no stray ready follows it
    //   the synchroniser clears, so the output starts low
    //   the lock clears and the key sequence returns to idle
    //
    // hazards for software:
    //   map the input before enabling the interrupt, or a stale low
    //   may read as an edge when the pin is first routed
    //   leave the lock set in normal running so a stray store
    //   cannot move a pin

    // map register storage and per-register constants
    logic [15:0] map_q [`RMP_NUM_MAP_REGS];
    logic [15:0] map_d [`RMP_NUM_MAP_REGS];
    logic [15:0] map_mask [`RMP_NUM_MAP_REGS];
    logic [15:0] map_rst [`RMP_NUM_MAP_REGS];

    // write lock and unlock sequence
    logic lock_q;
    logic lock_d;
    rmp_key_state_e key_q;
    rmp_key_state_e key_d;

    // bus answer
    logic pready_q;
    logic pready_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pslverr_q;
    logic pslverr_d;

    // pin synchroniser
    logic [NUM_PINS-1:0] pin_meta_q;
    logic [NUM_PINS-1:0] pin_meta_d;
    logic [NUM_PINS-1:0] pin_sync_q;
    logic [NUM_PINS-1:0] pin_sync_d;

    // interrupt 1 output
    logic irq1_q;
    logic irq1_d;

    // access decode
    logic wr_en;
    logic is_map;
    logic is_osc;
    logic [5:0] reg_idx;
    logic [4:0] irq1_sel;

    // access decode: a transfer completes on the edge pready is seen high
    assign wr_en = i_psel & i_penable & pready_q & i_pwrite;
    assign reg_idx = i_paddr[7:2];
    assign is_map = (i_paddr[1:0] == 2'h0) &&
                    (reg_idx < 6'(`RMP_NUM_MAP_REGS));
    assign is_osc = (i_paddr == `RMP_OSC_CTRL_OFFSET);

    // per-register masks, reset values and next values
    // seventeen remap registers
    genvar g;
    generate
        for (g = 0; g < `RMP_NUM_MAP_REGS; g++) begin : g_map
            if (g == `RMP_IRQ1_SEL_INDEX) begin : g_irq1
                assign map_mask[g] = `RMP_IRQ1_MASK;
                assign map_rst[g] = `RMP_IRQ1_RESET;
            end else if (g < `RMP_NUM_IN_REGS) begin : g_in
                assign map_mask[g] = `RMP_IN_MASK;
                assign map_rst[g] = `RMP_IN_RESET;
            end else begin : g_out
                assign map_mask[g] = `RMP_OUT_MASK;
                assign map_rst[g] = `RMP_OUT_RESET;
            end

            always_comb begin
                map_d[g] = map_q[g];
                if (wr_en && is_map && !lock_q &&
                    reg_idx == 6'(g)) begin
                    map_d[g] = i_pwdata[15:0] & map_mask[g];
                end
            end

            // map register storage
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    map_q[g] <= map_rst[g];
                end else begin
                    map_q[g] <= map_d[g];
                end
            end
        end
    endgenerate

    // unlock key sequence and lock bit
    // key sequence before lock change
    always_comb begin
        key_d = key_q;
        lock_d = lock_q;
        if (wr_en && is_osc) begin
            case (key_q)
                RMP_KEY_IDLE: begin
                    if (i_pwdata[7:0] == `RMP_KEY_FIRST) begin
                        key_d = RMP_KEY_GOT_FIRST;
                    end
                end
                RMP_KEY_GOT_FIRST: begin
                    if (i_pwdata[7:0] == `RMP_KEY_SECOND) begin
                        key_d = RMP_KEY_ARMED;
                    end else if (i_pwdata[7:0] == `RMP_KEY_FIRST) begin
                        key_d = RMP_KEY_GOT_FIRST;
                    end else begin
                        key_d = RMP_KEY_IDLE;
                    end
                end
                RMP_KEY_ARMED: begin
                    lock_d = i_pwdata[`RMP_LOCK_BIT];
                    key_d = RMP_KEY_IDLE;
                end
                default: begin
                    key_d = RMP_KEY_IDLE;
                end
            endcase
        end else if (wr_en) begin
            // any other write breaks the sequence
            key_d = RMP_KEY_IDLE;
        end
    end

    // key state and lock storage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            key_q <= RMP_KEY_IDLE;
            lock_q <= `RMP_LOCK_RESET;
        end else begin
            key_q <= key_d;
            lock_q <= lock_d;
        end
    end

    // apb answer: one wait-free access phase, data registered
    always_comb begin
        pready_d = i_psel & ~i_penable;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (i_psel && !i_penable) begin
            prdata_d = 32'h0000_0000;
            if (is_map) begin
                prdata_d = {16'h0000, map_q[reg_idx[4:0]]};
            end else if (is_osc) begin
                prdata_d[`RMP_LOCK_BIT] = lock_q;
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end

    // apb answer registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // synchroniser next values: only the second flop reads the first
    always_comb begin
        pin_meta_d = i_remappable_pin;
        pin_sync_d = pin_meta_q;
    end

    // two-flop synchroniser on the remappable pins
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_meta_d;
            pin_sync_q <= pin_sync_d;
        end
    end

    assign irq1_sel = map_q[`RMP_IRQ1_SEL_INDEX]
                      [`RMP_IRQ1_SEL_MSB:`RMP_IRQ1_SEL_LSB];

    // interrupt 1 input mux
    // field selects the pin
    always_comb begin
        irq1_d = 1'b0;
        if (irq1_sel == `RMP_PIN_SEL_TIED_LOW) begin
            irq1_d = 1'b0;
        end else if (irq1_sel <= `RMP_PIN_SEL_MAX &&
                     32'(irq1_sel) < NUM_PINS) begin
            irq1_d = pin_sync_q[irq1_sel];
        end
    end

    // peripheral-side output register
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq1_q <= 1'b0;
        end else begin
            irq1_q <= irq1_d;
        end
    end

    assign o_pready = pready_q;
    assign o_prdata = prdata_q;
    assign o_pslverr = pslverr_q;
    assign o_ext_irq1_input = irq1_q;
    assign o_pin_map_write_lock = lock_q;

endmodule
`default_nettype wire

// file: testbench/rmp_pin_remap_sva.sv
`timescale 1ns/100ps
`default_nettype none
module rmp_pin_remap_sva #(parameter int NUM_PINS = 26) (
    // apb side
    input wire logic i_clk, i_rst_n, i_psel, i_penable, i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata, o_prdata,
    input wire logic o_pready, o_pslverr,
    // pin side
    input wire logic [NUM_PINS-1:0] i_remappable_pin,
    input wire logic o_ext_irq1_input, o_pin_map_write_lock
);
    logic [NUM_PINS-1:0] p1_q, p2_q, p3_q;
    logic rd0;
    // pin history three edges deep
    always_ff @(posedge i_clk) begin
        p1_q <= i_remappable_pin;
        p2_q <= p1_q;
        p3_q <= p2_q;
    end
    // a completed read of the interrupt 1 select
    assign rd0 = o_pready && !i_pwrite && i_paddr == 8'h00;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    rdy_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("no ready after setup");
    rdy_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    err_unmapped_a: assert property (o_pready |-> o_pslverr == (i_paddr > 8'h44))
        else $error("error flag wrong for address");
    sel_unused_zero_a: assert property (rd0 |-> o_prdata[31:13] == 0 && o_prdata[7:0] == 0)
        else $error("unused select bits not zero");
    irq_pin_route_a: assert property (rd0 |-> o_ext_irq1_input == (o_prdata[12:8] < NUM_PINS ? p3_q[o_prdata[12:8]] : 1'b0))
        else $error("interrupt 1 not from selected pin");
    irq_tied_low_a: assert property (rd0 && o_prdata[12:8] == 5'h1f |-> !o_ext_irq1_input)
        else $error("interrupt 1 not tied low");
    lock_write_src_a: assert property ($changed(o_pin_map_write_lock) |-> $past(i_psel && i_penable && i_pwrite && i_paddr == 8'h44))
        else $error("lock moved without a write");
    lock_write_val_a: assert property ($changed(o_pin_map_write_lock) |-> o_pin_map_write_lock == $past(i_pwdata[6]))
        else $error("lock value not from write data");
    cover property (rd0 && o_pin_map_write_lock);
    cover property (o_pready && o_pslverr);
    cover property (rd0 && o_ext_irq1_input);
endmodule
bind rmp_pin_remap rmp_pin_remap_sva #(.NUM_PINS(NUM_PINS)) i_sva (.*);
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, r;
    logic o_pready, o_pslverr, o_ext_irq1_input, o_pin_map_write_lock, e;
    logic [25:0] i_remappable_pin = 0;
    logic [15:0] m_q [0:16];
    logic lk = 0;
    int ks = 0, err_count = 0, total_checks = 0, seed = 32'h8ddb, i, k;
    int sels [4] = '{0, 25, 31, 26};
    always #50 i_clk = ~i_clk;
    rmp_pin_remap i_dut (.*);
    task wrap_up;
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask
    // expected read data from the register model
    function logic [31:0] exp_rd(input logic [7:0] a);
        return a < 8'h44 ? m_q[a[7:2]] : a == 8'h44 ? {lk, 6'h0} : 0;
    endfunction
    // one apb transfer, then the model follows a write
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        chk(o_pin_map_write_lock, lk);
        i_psel <= 1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n == 20)
            err_count++;
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 0;
        i_penable <= 0;
        if (!w) begin
            chk(r, exp_rd(a));
            chk(e, a > 8'h44);
        end else if (a == 8'h44) begin
            if (ks == 2)
                lk = d[6];
            ks = ks == 2 ? 0 : d[7:0] == 8'h46 ? 1 :
                (ks == 1 && d[7:0] == 8'h57) ? 2 : 0;
        end else begin
            ks = 0;
            if (a < 8'h44 && !lk)
                m_q[a[7:2]] = d[15:0] & (a == 0 ? 16'h1f00 : 16'h1f1f);
        end
    endtask
    initial begin
        for (k = 0; k < 17; k++)
            m_q[k] = k == 0 ? 16'h1f00 : k < 9 ? 16'h1f1f : 16'h0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1;
        // reset values of every place, plus one unmapped
        for (i = 0; i < 19; i++)
            apb(0, 8'(i * 4), 0);
        // random traffic, locked in the middle third
        for (i = 0; i < 120; i++) begin
            if (i % 40 == 0) begin
                apb(1, 8'h44, 8'h46);
                apb(1, 8'h44, 8'h57);
                apb(1, 8'h44, {i == 40, 6'h0});
            end
            k = {$random(seed)} % 19;
            apb($random(seed), 8'(k * 4), $random(seed));
            apb(0, 8'(k * 4), 0);
        end
        // pin routing through the interrupt 1 select
        for (i = 0; i < 40; i++) begin
            k = i < 4 ? sels[i] : {$random(seed)} % 32;
            apb(1, 0, k << 8);
            @(posedge i_clk);
            i_remappable_pin <= $random(seed);
            repeat (4) @(posedge i_clk);
            chk(o_ext_irq1_input, k < 26 ? i_remappable_pin[k] : 0);
            apb(0, 0, 0);
        end
        wrap_up;
    end
    // watchdog
    initial begin
        #1000000;
        err_count++;
        wrap_up;
    end
endmodule
`default_nettype wire
